// ===== pkg/port_stats_pkg.sv
// port statistics package: register map, counter layout, event and state carriers
// assumes a 32-bit apb master and frame events from logic on the same clock
package port_stats_pkg;

  localparam int NUM_PORTS = 8;
  localparam int FRONT_PORTS = 4;
  localparam int NUM_COUNTERS = 15;
  localparam int CNT_W = 32;
  localparam int LEN_W = 16;
  localparam int FCS_OCTETS = 4;

  // register byte addresses
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_LINK = 12'h004;
  localparam logic [11:0] REG_IF_STATUS = 12'h008;
  localparam logic [11:0] REG_ADMIN = 12'h00c;
  localparam logic [11:0] REG_MTU = 12'h010;
  localparam logic [11:0] REG_QLEN = 12'h014;
  localparam logic [11:0] REG_CNT_BASE = 12'h100;
  localparam logic [11:0] REG_CNT_END = 12'h2ff;

  // control and link field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SEL_LSB = 4;
  localparam int CTRL_CLEAR_BIT = 8;
  localparam int LINK_DUPLEX_LSB = 8;

  // counter index within a port block of 16 words
  localparam int CNT_RX_FRAMES = 0;
  localparam int CNT_TX_FRAMES = 1;
  localparam int CNT_FILTERED = 2;
  localparam int CNT_FORWARDED = 3;
  localparam int CNT_IN_OCTETS = 4;
  localparam int CNT_IN_UCAST = 5;
  localparam int CNT_IN_NUCAST = 6;
  localparam int CNT_IN_DISCARD = 7;
  localparam int CNT_IN_ERROR = 8;
  localparam int CNT_IN_UNKNOWN = 9;
  localparam int CNT_OUT_OCTETS = 10;
  localparam int CNT_OUT_UCAST = 11;
  localparam int CNT_OUT_NUCAST = 12;
  localparam int CNT_OUT_DISCARD = 13;
  localparam int CNT_OUT_ERROR = 14;
  localparam int SWITCH_CNT_LAST = 3;

  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_TRANSPARENT = 2'h1,
    MODE_VLAN = 2'h2,
    MODE_RSVD = 2'h3
  } op_mode_type;

  typedef enum logic [1:0] {
    IF_UP = 2'h0,
    IF_DOWN = 2'h1,
    IF_TESTING = 2'h2,
    IF_RSVD = 2'h3
  } if_status_type;

  typedef enum logic [1:0] {
    DEST_UNICAST = 2'h0,
    DEST_MULTICAST = 2'h1,
    DEST_BROADCAST = 2'h2,
    DEST_RSVD = 2'h3
  } dest_class_type;

  typedef struct packed {
    logic rx_frame;
    logic [LEN_W-1:0] rx_len;
    dest_class_type rx_class;
    logic rx_drop_good;
    logic rx_drop_error;
    logic rx_drop_unknown;
    logic filtered;
    logic forwarded;
    logic tx_frame;
    logic [LEN_W-1:0] tx_len;
    dest_class_type tx_class;
    logic tx_drop_good;
    logic tx_drop_error;
  } port_event_type;

  typedef struct packed {
    logic [NUM_PORTS-1:0][NUM_COUNTERS-1:0][CNT_W-1:0] cnt;
    op_mode_type mode;
    logic [2:0] sel;
    logic [NUM_PORTS-1:0][1:0] admin;
    logic [NUM_PORTS-1:0] link_meta;
    logic [NUM_PORTS-1:0] link;
    logic [NUM_PORTS-1:0] duplex_meta;
    logic [NUM_PORTS-1:0] duplex;
    logic [31:0] rdata;
    logic slverr;
  } state_type;

endpackage : port_stats_pkg

// ===== logic/port_stats.sv
// per-port frame statistics for an eight-port switch, apb register slave
// assumes frame events from same-clock mac logic; link and duplex come from pins
//
// Contract
// - eight ports kept; ports five to eight are backplane, counted identically.
// - each port counts received, transmitted, filtered and forwarded frames separately.
// - switch frame counters read only in transparent or vlan bridging mode.
// - clear command zeroes every counter of the selected interface.
// - received octets add every frame length, bad frames included.
// - inbound unicast counts received frames with unicast destination.
// - inbound non-unicast counts received broadcast or multicast frames.
// - inbound discard counts error-free received frames that were dropped.
// - inbound error counts once each received frame dropped for any error.
// - unknown-protocol counts received frames dropped for unknown format.
// - transmitted octets add every sent octet including four fcs octets.
// - outbound unicast counts frames sent to a single destination.
// - outbound non-unicast counts frames sent to broadcast or multicast.
// - outbound discard counts error-free frames dropped before transmission.
// - outbound error counts once each outbound frame dropped for an error.
// - each interface reports its outbound queue capacity.
// - interface in testing status passes no frames.
// - link state reads as link present or no link.
// - duplex state reads as half or full duplex.
// - each interface reports its largest frame data field in octets.
`timescale 1ns/100ps

module port_stats #(
  parameter logic [15:0] MTU_OCTETS = 16'd1514,
  parameter logic [15:0] QUEUE_DEPTH = 16'd64
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // frame events from macs and forwarding engine
  input wire port_stats_pkg::port_event_type [port_stats_pkg::NUM_PORTS-1:0] events,
  input wire logic [port_stats_pkg::NUM_PORTS-1:0][1:0] oper_status,
  // phy pins
  input wire logic [port_stats_pkg::NUM_PORTS-1:0] link_up_pin,
  input wire logic [port_stats_pkg::NUM_PORTS-1:0] full_duplex_pin,
  // frame gate toward the macs
  output logic [port_stats_pkg::NUM_PORTS-1:0] pass_en
);
  import port_stats_pkg::*;

  state_type st;
  state_type next_st;
  logic apb_setup;
  logic apb_write;
  logic clear_hit;
  logic [2:0] clear_port;
  logic bridging;
  logic [NUM_COUNTERS-1:0][CNT_W-1:0] add;
  logic [2:0] rd_port;
  logic [3:0] rd_idx;
  logic [11:0] cnt_off;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign prdata = st.rdata;
  assign pslverr = st.slverr;
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pwrite;
  assign clear_hit = apb_write && paddr == REG_CTRL && pwdata[CTRL_CLEAR_BIT];
  assign clear_port = pwdata[CTRL_SEL_LSB +: 3];
  assign bridging = st.mode == MODE_TRANSPARENT || st.mode == MODE_VLAN;
  // counter offset from the block base, port in [8:6]
  assign cnt_off = paddr - REG_CNT_BASE;
  assign rd_port = cnt_off[8:6];
  assign rd_idx = cnt_off[5:2];

  // ----------------------------------------------------------------
  // frame gate
  // ----------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_gate
      assign pass_en[gp] = st.admin[gp] != IF_TESTING && oper_status[gp] != IF_TESTING;
    end
  endgenerate

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  function automatic logic [32:0] read_word(input state_type s, input logic [11:0] a,
                                            input logic brg, input logic [NUM_PORTS-1:0] pe,
                                            input logic [NUM_PORTS-1:0][1:0] oper);
    logic [32:0] r;
    logic [2:0] p;
    logic [3:0] i;
    logic [11:0] o;
    r = 33'h000000000;
    o = a - REG_CNT_BASE;
    p = o[8:6];
    i = o[5:2];
    if (a == REG_CTRL) begin
      r[CTRL_MODE_LSB +: 2] = s.mode;
      r[CTRL_SEL_LSB +: 3] = s.sel;
    end else if (a == REG_LINK) begin
      r[NUM_PORTS-1:0] = s.link;
      r[LINK_DUPLEX_LSB +: NUM_PORTS] = s.duplex;
    end else if (a == REG_IF_STATUS) begin
      r[6:0] = {pe[s.sel], s.duplex[s.sel], s.link[s.sel], oper[s.sel], s.admin[s.sel]};
    end else if (a == REG_ADMIN) begin
      r[2*NUM_PORTS-1:0] = s.admin;
    end else if (a == REG_MTU) begin
      r[15:0] = MTU_OCTETS;
    end else if (a == REG_QLEN) begin
      r[15:0] = QUEUE_DEPTH;
    end else if (a >= REG_CNT_BASE && a <= REG_CNT_END && a[1:0] == 2'h0 && 32'(i) < NUM_COUNTERS) begin
      if (32'(i) > SWITCH_CNT_LAST || brg) begin
        r[31:0] = s.cnt[p][i];
      end
    end else begin
      r[32] = 1'b1;
    end
    return r;
  endfunction : read_word

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    add = '0;
    next_st.link_meta = link_up_pin;
    next_st.link = st.link_meta;
    next_st.duplex_meta = full_duplex_pin;
    next_st.duplex = st.duplex_meta;
    if (apb_setup) begin
      {next_st.slverr, next_st.rdata} = read_word(st, paddr, bridging, pass_en, oper_status);
    end
    if (apb_write && paddr == REG_CTRL) begin
      next_st.mode = op_mode_type'(pwdata[CTRL_MODE_LSB +: 2]);
      next_st.sel = pwdata[CTRL_SEL_LSB +: 3];
    end
    if (apb_write && paddr == REG_ADMIN) begin
      next_st.admin = pwdata[2*NUM_PORTS-1:0];
    end
    for (int p = 0; p < NUM_PORTS; p++) begin
      add = '0;
      if (pass_en[p]) begin
        add[CNT_RX_FRAMES] = 32'(events[p].rx_frame);
        add[CNT_TX_FRAMES] = 32'(events[p].tx_frame);
        add[CNT_FILTERED] = 32'(events[p].filtered);
        add[CNT_FORWARDED] = 32'(events[p].forwarded);
        add[CNT_IN_OCTETS] = events[p].rx_frame ? 32'(events[p].rx_len) : 32'h00000000;
        add[CNT_IN_UCAST] = 32'(events[p].rx_frame && events[p].rx_class == DEST_UNICAST);
        add[CNT_IN_NUCAST] = 32'(events[p].rx_frame && (events[p].rx_class == DEST_MULTICAST ||
                                                       events[p].rx_class == DEST_BROADCAST));
        add[CNT_IN_DISCARD] = 32'(events[p].rx_drop_good);
        add[CNT_IN_ERROR] = 32'(events[p].rx_drop_error);
        add[CNT_IN_UNKNOWN] = 32'(events[p].rx_drop_unknown);
        add[CNT_OUT_OCTETS] = events[p].tx_frame ? 32'(events[p].tx_len) + 32'(FCS_OCTETS) : 32'h00000000;
        add[CNT_OUT_UCAST] = 32'(events[p].tx_frame && events[p].tx_class == DEST_UNICAST);
        add[CNT_OUT_NUCAST] = 32'(events[p].tx_frame && (events[p].tx_class == DEST_MULTICAST ||
                                                        events[p].tx_class == DEST_BROADCAST));
        add[CNT_OUT_DISCARD] = 32'(events[p].tx_drop_good);
        add[CNT_OUT_ERROR] = 32'(events[p].tx_drop_error);
      end
      for (int c = 0; c < NUM_COUNTERS; c++) begin
        // event in the clearing cycle still counts; add wraps modulo 2^32
        if (clear_hit && clear_port == 3'(p)) begin
          next_st.cnt[p][c] = add[c];
        end else begin
          next_st.cnt[p][c] = st.cnt[p][c] + add[c];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence seq_read_setup(logic [11:0] a);
    apb_setup && paddr == a;
  endsequence

  sequence seq_clear_write;
    clear_hit;
  endsequence

  sequence seq_cnt_read;
    apb_setup && paddr >= REG_CNT_BASE && paddr <= REG_CNT_END && paddr[1:0] == 2'h0 && rd_idx != 4'hf;
  endsequence

  a_switch_gate: assert property (@(posedge clk) disable iff (srst)
    seq_cnt_read ##0 (32'(rd_idx) <= SWITCH_CNT_LAST && !bridging) |=> prdata == 32'h00000000)
    else $error("switch counter visible outside bridging mode");

  a_cnt_read: assert property (@(posedge clk) disable iff (srst)
    seq_cnt_read ##0 (bridging || 32'(rd_idx) > SWITCH_CNT_LAST)
    |=> prdata == $past(st.cnt[rd_port][rd_idx]) && !pslverr)
    else $error("counter read from the wrong port or index");

  a_clear_errors: assert property (@(posedge clk) disable iff (srst)
    seq_clear_write |=> st.cnt[st.sel][CNT_IN_ERROR] <= 32'h00000001 &&
                        st.cnt[st.sel][CNT_OUT_ERROR] <= 32'h00000001)
    else $error("clear left an error counter of the selected interface");

  a_clear_zero: assert property (@(posedge clk) disable iff (srst)
    seq_clear_write |=> st.cnt[st.sel][CNT_RX_FRAMES] <= 32'h00000001 &&
                        st.cnt[st.sel][CNT_IN_OCTETS] <= 32'(16'hffff))
    else $error("clear left a counter of the selected interface");

  a_qlen_read: assert property (@(posedge clk) disable iff (srst)
    seq_read_setup(REG_QLEN) ##1 psel && penable |-> prdata == 32'(QUEUE_DEPTH) && !pslverr)
    else $error("queue capacity misreported");

  a_mtu_read: assert property (@(posedge clk) disable iff (srst)
    seq_read_setup(REG_MTU) |=> prdata == 32'(MTU_OCTETS))
    else $error("mtu misreported");

  a_link_read: assert property (@(posedge clk) disable iff (srst)
    seq_read_setup(REG_LINK) |=> prdata[NUM_PORTS-1:0] == $past(st.link))
    else $error("link state misreported");

  a_duplex_read: assert property (@(posedge clk) disable iff (srst)
    seq_read_setup(REG_LINK) |=> prdata[LINK_DUPLEX_LSB +: NUM_PORTS] == $past(st.duplex))
    else $error("duplex state misreported");

  a_status_read: assert property (@(posedge clk) disable iff (srst)
    seq_read_setup(REG_IF_STATUS) |=> prdata[6:4] == $past({pass_en[st.sel], st.duplex[st.sel], st.link[st.sel]}))
    else $error("selected interface status misreported");

  a_reset_zero: assert property (@(posedge clk) srst |=> st.cnt == '0)
    else $error("counters not zero after reset");

  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_chk
      a_testing_block: assert property (@(posedge clk) disable iff (srst)
        st.admin[gp] == IF_TESTING |-> !pass_en[gp])
        else $error("testing interface passes frames");

      a_oper_block: assert property (@(posedge clk) disable iff (srst)
        oper_status[gp] == IF_TESTING |-> !pass_en[gp])
        else $error("operational testing interface passes frames");

      a_gated_hold: assert property (@(posedge clk) disable iff (srst)
        !pass_en[gp] && !clear_hit |=> st.cnt[gp][CNT_RX_FRAMES] == $past(st.cnt[gp][CNT_RX_FRAMES]) &&
                                       st.cnt[gp][CNT_TX_FRAMES] == $past(st.cnt[gp][CNT_TX_FRAMES]))
        else $error("testing interface counted a frame");

      a_rx_frames: assert property (@(posedge clk) disable iff (srst)
        pass_en[gp] && events[gp].rx_frame && !(clear_hit && clear_port == 3'(gp))
        |=> st.cnt[gp][CNT_RX_FRAMES] == $past(st.cnt[gp][CNT_RX_FRAMES]) + 32'h00000001)
        else $error("received frame not counted");

      a_rx_octets: assert property (@(posedge clk) disable iff (srst)
        pass_en[gp] && events[gp].rx_frame && events[gp].rx_drop_error && !clear_hit
        |=> st.cnt[gp][CNT_IN_OCTETS] == $past(st.cnt[gp][CNT_IN_OCTETS]) + 32'($past(events[gp].rx_len)))
        else $error("bad frame octets not counted");

      a_tx_octets: assert property (@(posedge clk) disable iff (srst)
        pass_en[gp] && events[gp].tx_frame && !clear_hit
        |=> st.cnt[gp][CNT_OUT_OCTETS] ==
            $past(st.cnt[gp][CNT_OUT_OCTETS]) + 32'($past(events[gp].tx_len)) + 32'(FCS_OCTETS))
        else $error("transmit octets miss the fcs");

      a_in_error_once: assert property (@(posedge clk) disable iff (srst)
        !clear_hit |=> st.cnt[gp][CNT_IN_ERROR] - $past(st.cnt[gp][CNT_IN_ERROR]) ==
                       32'($past(pass_en[gp] && events[gp].rx_drop_error)))
        else $error("inbound error count off");

      // modular difference also covers the wrap from all ones to zero
      a_wrap_zero: assert property (@(posedge clk) disable iff (srst)
        !clear_hit |=> st.cnt[gp][CNT_TX_FRAMES] - $past(st.cnt[gp][CNT_TX_FRAMES]) ==
                       32'($past(pass_en[gp] && events[gp].tx_frame)))
        else $error("transmit frame count not a single modular step");

      a_filt_count: assert property (@(posedge clk) disable iff (srst)
        !clear_hit |=> st.cnt[gp][CNT_FILTERED] - $past(st.cnt[gp][CNT_FILTERED]) ==
                       32'($past(pass_en[gp] && events[gp].filtered)))
        else $error("filtered count off");

      a_fwd_count: assert property (@(posedge clk) disable iff (srst)
        !clear_hit |=> st.cnt[gp][CNT_FORWARDED] - $past(st.cnt[gp][CNT_FORWARDED]) ==
                       32'($past(pass_en[gp] && events[gp].forwarded)))
        else $error("forwarded count off");

      a_in_ucast: assert property (@(posedge clk) disable iff (srst)
        !clear_hit |=> st.cnt[gp][CNT_IN_UCAST] - $past(st.cnt[gp][CNT_IN_UCAST]) ==
                       32'($past(pass_en[gp] && events[gp].rx_frame && events[gp].rx_class == DEST_UNICAST)))
        else $error("inbound unicast count off");

      a_in_nucast: assert property (@(posedge clk) disable iff (srst)
        !clear_hit |=> st.cnt[gp][CNT_IN_NUCAST] - $past(st.cnt[gp][CNT_IN_NUCAST]) ==
                       32'($past(pass_en[gp] && events[gp].rx_frame &&
                                 events[gp].rx_class inside {DEST_MULTICAST, DEST_BROADCAST})))
        else $error("inbound non-unicast count off");

      a_in_discard: assert property (@(posedge clk) disable iff (srst)
        !clear_hit |=> st.cnt[gp][CNT_IN_DISCARD] - $past(st.cnt[gp][CNT_IN_DISCARD]) ==
                       32'($past(pass_en[gp] && events[gp].rx_drop_good)))
        else $error("inbound discard count off");

      a_in_unknown: assert property (@(posedge clk) disable iff (srst)
        !clear_hit |=> st.cnt[gp][CNT_IN_UNKNOWN] - $past(st.cnt[gp][CNT_IN_UNKNOWN]) ==
                       32'($past(pass_en[gp] && events[gp].rx_drop_unknown)))
        else $error("unknown format count off");

      a_out_ucast: assert property (@(posedge clk) disable iff (srst)
        !clear_hit |=> st.cnt[gp][CNT_OUT_UCAST] - $past(st.cnt[gp][CNT_OUT_UCAST]) ==
                       32'($past(pass_en[gp] && events[gp].tx_frame && events[gp].tx_class == DEST_UNICAST)))
        else $error("outbound unicast count off");

      a_out_nucast: assert property (@(posedge clk) disable iff (srst)
        !clear_hit |=> st.cnt[gp][CNT_OUT_NUCAST] - $past(st.cnt[gp][CNT_OUT_NUCAST]) ==
                       32'($past(pass_en[gp] && events[gp].tx_frame &&
                                 events[gp].tx_class inside {DEST_MULTICAST, DEST_BROADCAST})))
        else $error("outbound non-unicast count off");

      a_out_discard: assert property (@(posedge clk) disable iff (srst)
        !clear_hit |=> st.cnt[gp][CNT_OUT_DISCARD] - $past(st.cnt[gp][CNT_OUT_DISCARD]) ==
                       32'($past(pass_en[gp] && events[gp].tx_drop_good)))
        else $error("outbound discard count off");

      a_out_error: assert property (@(posedge clk) disable iff (srst)
        !clear_hit |=> st.cnt[gp][CNT_OUT_ERROR] - $past(st.cnt[gp][CNT_OUT_ERROR]) ==
                       32'($past(pass_en[gp] && events[gp].tx_drop_error)))
        else $error("outbound error count off");
    end
  endgenerate

endmodule : port_stats

// ===== test/mac_events_model.sv
// frame event source standing in for the port macs and forwarding engine
// assumes the bench commands one port and one event kind per cycle of go
`timescale 1ns/100ps

module mac_events_model
  import port_stats_pkg::*;
(
  // clock
  input wire logic clk,
  // command from the bench
  input wire logic go,
  input wire logic [2:0] port,
  input wire logic [3:0] kind,
  input wire logic [15:0] len,
  input wire dest_class_type cls,
  // event pulses toward the block
  output port_event_type [NUM_PORTS-1:0] events
);
  // ----------------------------------------
  // pulses, with changing junk in idle fields
  // ----------------------------------------
  logic [15:0] junk = 16'ha5c3;
  initial events = '0;
  always @(posedge clk) begin
    junk <= {junk[14:0], junk[15] ^ junk[13]};
    for (int i = 0; i < NUM_PORTS; i++) begin
      events[i] <= '0;
      events[i].rx_len <= junk;
      events[i].tx_len <= ~junk;
      events[i].rx_class <= dest_class_type'(junk[1:0]);
      events[i].tx_class <= dest_class_type'(junk[3:2]);
    end
    if (go) begin
      // a frame dropped for an error was still received, with its length
      events[port].rx_frame <= kind == 4'h0 || kind == 4'h2;
      events[port].rx_drop_good <= kind == 4'h1;
      events[port].rx_drop_error <= kind == 4'h2;
      events[port].rx_drop_unknown <= kind == 4'h3;
      events[port].filtered <= kind == 4'h4;
      events[port].forwarded <= kind == 4'h5;
      events[port].tx_frame <= kind == 4'h6;
      events[port].tx_drop_good <= kind == 4'h7;
      events[port].tx_drop_error <= kind == 4'h8;
      events[port].rx_len <= len;
      events[port].tx_len <= len;
      events[port].rx_class <= cls;
      events[port].tx_class <= cls;
    end
  end
endmodule : mac_events_model

// ===== test/switch_port_statistics_tb_top.sv
// self-checking bench for the port statistics block
// assumes apb master here, frame events from mac_events_model
`timescale 1ns/100ps

module switch_port_statistics_tb_top;
  import port_stats_pkg::*;
  localparam logic [15:0] MTU = 16'h05ea;
  localparam logic [15:0] QD = 16'h0040;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, go;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [7:0] link_pin, dup_pin, pass_en;
  logic [7:0][1:0] oper;
  logic [2:0] ev_port;
  logic [3:0] ev_kind;
  logic [15:0] ev_len;
  dest_class_type ev_cls;
  port_event_type [NUM_PORTS-1:0] events;
  logic [32:0] q[$];
  logic [31:0] ec [8][15];
  logic [1:0] adm [8];
  logic [1:0] mode;
  int kind_cnt [9] = '{0, 7, 8, 9, 2, 3, 1, 13, 14};
  int fails, compares;

  port_stats #(.MTU_OCTETS(MTU), .QUEUE_DEPTH(QD)) dut (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .events(events), .oper_status(oper), .link_up_pin(link_pin),
    .full_duplex_pin(dup_pin), .pass_en(pass_en));
  mac_events_model src (.clk(clk), .go(go), .port(ev_port), .kind(ev_kind), .len(ev_len), .cls(ev_cls),
    .events(events));

  // ----------------------------------------
  // clock, helpers, compares
  // ----------------------------------------
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task final_report;
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  task check_rd(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t read got %h expected %h", $time, got, exp);
    end
  endtask : check_rd

  task check_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t pass_en got %b expected %b", $time, got, exp);
    end
  endtask : check_bit

  // read results taken at the access edge
  always @(posedge clk) if (psel && penable && pready && !pwrite) check_rd({pslverr, prdata}, q.pop_front());

  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    final_report();
  end

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) q.push_back(e);
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) begin
      fails++;
      final_report();
    end
    psel <= 0;
    penable <= 0;
  endtask : apb

  task rd(input logic [11:0] a, input logic [31:0] e, input logic err = 0);
    apb(0, a, 0, {err, e});
  endtask : rd

  task check_port(input int p);
    for (int i = 0; i < 15; i++)
      rd(REG_CNT_BASE + 12'(p * 64 + i * 4), (i <= SWITCH_CNT_LAST && !(mode inside {1, 2})) ? 0 : ec[p][i]);
  endtask : check_port

  task send(input int p, input int k, input dest_class_type c, input int n);
    logic [15:0] len;
    int b;
    rnd = lfsr(rnd);
    len = rnd[15:0];
    b = (k == 6) ? 10 : 4;
    @(posedge clk);
    go <= 1;
    ev_port <= 3'(p);
    ev_kind <= 4'(k);
    ev_len <= len;
    ev_cls <= c;
    repeat (n) @(posedge clk);
    go <= 0;
    repeat (3) @(posedge clk);
    if (adm[p] != 2 && oper[p] != 2) repeat (n) begin
      ec[p][kind_cnt[k]]++;
      if (k == 0 || k == 2 || k == 6) begin
        if (k == 2) ec[p][CNT_RX_FRAMES]++;
        ec[p][b] += {16'h0, len} + ((k == 6) ? 32'h4 : 32'h0);
        if (c == DEST_UNICAST) ec[p][b + 1]++;
        else if (c != DEST_RSVD) ec[p][b + 2]++;
      end
    end
  endtask : send

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    srst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; go = 0; ev_port = 0;
    ev_kind = 0; ev_len = 0; ev_cls = DEST_UNICAST; link_pin = 0; dup_pin = 0; oper = '0;
    rnd = 32'haa12; mode = 0; fails = 0; compares = 0;
    foreach (ec[p, i]) ec[p][i] = 0;
    foreach (adm[p]) adm[p] = 0;
    repeat (3) @(posedge clk);
    srst <= 0;
    rd(REG_CTRL, 0);
    rd(REG_MTU, {16'h0, MTU});
    rd(REG_QLEN, {16'h0, QD});
    rd(12'h018, 0, 1);
    rd(12'h13c, 0, 1);
    check_port(7);
    send(7, 0, DEST_UNICAST, 1);
    for (int m = 0; m < 4; m++) begin
      apb(1, REG_CTRL, 32'(m), 0);
      mode = 2'(m);
      check_port(7);
    end
    apb(1, REG_CTRL, 32'h1, 0);
    mode = 1;
    for (int p = 0; p < 8; p++) begin
      for (int k = 0; k < 9; k++) send(p, k, dest_class_type'((p + k) % 4), 1 + p % 2);
      check_port(p);
    end
    apb(1, REG_CTRL, 32'h151, 0);
    foreach (ec[5][i]) ec[5][i] = 0;
    check_port(5);
    check_port(4);
    rd(REG_CTRL, 32'h51);
    apb(1, REG_ADMIN, 32'h20, 0);
    adm[2] = 2;
    oper[3] <= 2'h2;
    @(posedge clk);
    @(posedge clk);
    check_bit(pass_en[2], 1'b0);
    check_bit(pass_en[3], 1'b0);
    check_bit(pass_en[4], 1'b1);
    send(2, 0, DEST_UNICAST, 1);
    send(3, 6, DEST_BROADCAST, 1);
    check_port(2);
    check_port(3);
    rd(REG_ADMIN, 32'h20);
    rnd = lfsr(rnd);
    link_pin <= rnd[7:0];
    dup_pin <= rnd[15:8];
    repeat (4) @(posedge clk);
    rd(REG_LINK, {16'h0, dup_pin, link_pin});
    rd(REG_IF_STATUS, {25'h0, 1'b1, dup_pin[5], link_pin[5], 4'h0});
    repeat (4) @(posedge clk);
    final_report();
  end
endmodule : switch_port_statistics_tb_top
